// ### src/bsc_chain.sv
// boundary-scan cell chain with its test access port, sampled on ref_clk
// Notes on behaviour
// - one scan chain of 256 cells over all pins and their controls
// - each input pin has one cell capturing the pin level
// - each output pin has a pair; drive cell holds value forced on pad
// - output pin control cell can switch the pad driver off
// - each bidirectional pin has three cells: drive, observe, direction
// - bidirectional drive cell holds value forced on pad in test mode
// - bidirectional observe cell captures level applied to the pad
// - bidirectional control cell sets pad direction, driven or input
`timescale 1ns/100ps

module bsc_chain
   import bsc_pkg::*;
#(
   parameter int CHAIN_LEN = BSC_CHAIN_LEN,
   parameter int N_IN = BSC_N_IN,
   parameter int N_OUT = BSC_N_OUT,
   parameter int N_BIDI = (CHAIN_LEN - N_IN * BSC_IN_CELLS - N_OUT * BSC_OUT_CELLS)
                          / BSC_BIDI_CELLS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // jtag link from the tester
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // input-only pads and their core side
   input wire logic [N_IN-1:0] in_pad_i,
   output logic [N_IN-1:0] core_in,
   // output-only pads and their core side
   input wire logic [N_OUT-1:0] core_out_d,
   input wire logic [N_OUT-1:0] core_out_en,
   output logic [N_OUT-1:0] out_pad_o,
   output logic [N_OUT-1:0] out_pad_oe,
   // bidirectional pads and their core side
   input wire logic [N_BIDI-1:0] bidi_pad_i,
   output logic [N_BIDI-1:0] bidi_pad_o,
   output logic [N_BIDI-1:0] bidi_pad_oe,
   input wire logic [N_BIDI-1:0] core_bidi_d,
   input wire logic [N_BIDI-1:0] core_bidi_en,
   output logic [N_BIDI-1:0] core_bidi_in,
   // test mode indication
   output logic test_mode
);

   // ==========================================================
   // cell positions
   function automatic int in_cell(input int i);
      in_cell = CHAIN_LEN - 1 - i * BSC_IN_CELLS;
   endfunction : in_cell

   function automatic int out_top(input int j);
      out_top = CHAIN_LEN - 1 - N_IN * BSC_IN_CELLS - j * BSC_OUT_CELLS;
   endfunction : out_top

   function automatic int bidi_top(input int k);
      bidi_top = CHAIN_LEN - 1 - N_IN * BSC_IN_CELLS - N_OUT * BSC_OUT_CELLS
                 - k * BSC_BIDI_CELLS;
   endfunction : bidi_top

   // ==========================================================
   // tap next state
   function automatic bsc_tap_t tap_next(input bsc_tap_t st, input logic m);
      case (st)
         TAP_RESET:      tap_next = m ? TAP_RESET : TAP_IDLE;
         TAP_IDLE:       tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR:     tap_next = m ? TAP_SEL_IR : TAP_CAPTURE_DR;
         TAP_CAPTURE_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_SHIFT_DR:   tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
         TAP_EXIT1_DR:   tap_next = m ? TAP_UPDATE_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR:   tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
         TAP_EXIT2_DR:   tap_next = m ? TAP_UPDATE_DR : TAP_SHIFT_DR;
         TAP_UPDATE_DR:  tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR:     tap_next = m ? TAP_RESET : TAP_CAPTURE_IR;
         TAP_CAPTURE_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_SHIFT_IR:   tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
         TAP_EXIT1_IR:   tap_next = m ? TAP_UPDATE_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR:   tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
         TAP_EXIT2_IR:   tap_next = m ? TAP_UPDATE_IR : TAP_SHIFT_IR;
         TAP_UPDATE_IR:  tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         default:        tap_next = TAP_RESET;
      endcase
   endfunction : tap_next

   // ==========================================================
   // synchronised link and pad inputs
   logic [2:0] link_s;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic [N_BIDI-1:0] bidi_s;

   bsc_sync #(.W(3)) u_link_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .d({tck, tms, tdi}),
      .q(link_s)
   );

   bsc_sync #(.W(N_IN)) u_in_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .d(in_pad_i),
      .q(core_in)
   );

   bsc_sync #(.W(N_BIDI)) u_bidi_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .d(bidi_pad_i),
      .q(bidi_s)
   );

   assign tck_s = link_s[2];
   assign tms_s = link_s[1];
   assign tdi_s = link_s[0];
   assign core_bidi_in = bidi_s;

   // ==========================================================
   // state
   typedef struct packed {
      bsc_tap_t tap;
      logic [BSC_IR_W-1:0] ir_sh;
      logic [BSC_IR_W-1:0] ir;
      logic [CHAIN_LEN-1:0] chain;
      logic [CHAIN_LEN-1:0] upd;
      logic byp;
      logic tdo;
      logic tdo_oe;
      logic tck_dly;
      logic [N_OUT-1:0] out_o;
      logic [N_OUT-1:0] out_oe;
      logic [N_BIDI-1:0] bidi_o;
      logic [N_BIDI-1:0] bidi_oe;
   } bsc_state_t;

   bsc_state_t s_q;
   bsc_state_t s_d;
   logic tck_rise;
   logic tck_fall;
   logic extest;
   logic chain_sel;

   assign tck_rise = tck_s & ~s_q.tck_dly;
   assign tck_fall = ~tck_s & s_q.tck_dly;
   assign extest = (s_q.ir == BSC_IR_EXTEST);
   assign chain_sel = extest | (s_q.ir == BSC_IR_SAMPLE);

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.tck_dly = tck_s;
      if (tck_rise) begin
         s_d.tap = tap_next(s_q.tap, tms_s);
         case (s_q.tap)
            TAP_CAPTURE_DR: begin
               s_d.byp = 1'b0;
               for (int i = 0; i < N_IN; i++) begin
                  s_d.chain[in_cell(i)] = core_in[i];
               end
               for (int j = 0; j < N_OUT; j++) begin
                  s_d.chain[out_top(j) - BSC_OFS_DRIVE] = core_out_d[j];
                  s_d.chain[out_top(j) - BSC_OFS_CTRL_OUT] = core_out_en[j];
               end
               for (int k = 0; k < N_BIDI; k++) begin
                  s_d.chain[bidi_top(k) - BSC_OFS_DRIVE] = core_bidi_d[k];
                  s_d.chain[bidi_top(k) - BSC_OFS_OBSERVE] = bidi_s[k];
                  s_d.chain[bidi_top(k) - BSC_OFS_CTRL_BIDI] = core_bidi_en[k];
               end
            end
            TAP_SHIFT_DR: begin
               if (chain_sel) begin
                  s_d.chain = {tdi_s, s_q.chain[CHAIN_LEN-1:1]};
               end else begin
                  s_d.byp = tdi_s;
               end
            end
            TAP_CAPTURE_IR: begin
               s_d.ir_sh = BSC_IR_CAPTURE;
            end
            TAP_SHIFT_IR: begin
               s_d.ir_sh = {tdi_s, s_q.ir_sh[BSC_IR_W-1:1]};
            end
            default: begin
            end
         endcase
      end
      if (tck_fall) begin
         s_d.tdo_oe = 1'b0;
         case (s_q.tap)
            TAP_SHIFT_DR: begin
               s_d.tdo = chain_sel ? s_q.chain[0] : s_q.byp;
               s_d.tdo_oe = 1'b1;
            end
            TAP_SHIFT_IR: begin
               s_d.tdo = s_q.ir_sh[0];
               s_d.tdo_oe = 1'b1;
            end
            TAP_UPDATE_DR: begin
               if (chain_sel) begin
                  s_d.upd = s_q.chain;
               end
            end
            TAP_UPDATE_IR: begin
               s_d.ir = s_q.ir_sh;
            end
            TAP_RESET: begin
               s_d.ir = BSC_IR_BYPASS;
            end
            default: begin
            end
         endcase
      end
      // pads follow the update cells only in test mode
      for (int j = 0; j < N_OUT; j++) begin
         s_d.out_o[j] = extest ? s_q.upd[out_top(j) - BSC_OFS_DRIVE] : core_out_d[j];
         s_d.out_oe[j] = extest ? s_q.upd[out_top(j) - BSC_OFS_CTRL_OUT]
                                : core_out_en[j];
      end
      for (int k = 0; k < N_BIDI; k++) begin
         s_d.bidi_o[k] = extest ? s_q.upd[bidi_top(k) - BSC_OFS_DRIVE] : core_bidi_d[k];
         s_d.bidi_oe[k] = extest ? s_q.upd[bidi_top(k) - BSC_OFS_CTRL_BIDI]
                                 : core_bidi_en[k];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.tap <= TAP_RESET;
         s_q.ir <= BSC_IR_BYPASS;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   assign tdo = s_q.tdo;
   assign tdo_oe = s_q.tdo_oe;
   assign out_pad_o = s_q.out_o;
   assign out_pad_oe = s_q.out_oe;
   assign bidi_pad_o = s_q.bidi_o;
   assign bidi_pad_oe = s_q.bidi_oe;
   assign test_mode = extest;

endmodule : bsc_chain

// ### src/bsc_pkg.sv
// shared constants and types of the boundary-scan cell chain
package bsc_pkg;

   // ==========================================================
   // chain geometry
   localparam int BSC_CHAIN_LEN = 256;
   localparam int BSC_N_IN = 4;
   localparam int BSC_N_OUT = 6;
   localparam int BSC_IN_CELLS = 1;
   localparam int BSC_OUT_CELLS = 2;
   localparam int BSC_BIDI_CELLS = 3;
   // offsets inside a group, counted down from the group's top cell
   localparam int BSC_OFS_DRIVE = 0;
   localparam int BSC_OFS_OBSERVE = 1;
   localparam int BSC_OFS_CTRL_OUT = 1;
   localparam int BSC_OFS_CTRL_BIDI = 2;

   // ==========================================================
   // instruction register
   localparam int BSC_IR_W = 4;
   localparam logic [BSC_IR_W-1:0] BSC_IR_EXTEST = 4'h0;
   localparam logic [BSC_IR_W-1:0] BSC_IR_SAMPLE = 4'h1;
   localparam logic [BSC_IR_W-1:0] BSC_IR_BYPASS = 4'hF;
   localparam logic [BSC_IR_W-1:0] BSC_IR_CAPTURE = 4'h1;

   // ==========================================================
   // link timing and sampling
   localparam int BSC_SYNC_STAGES = 2;
   localparam int BSC_REF_CLK_NS = 40;
   localparam int BSC_TCK_MIN_PERIOD_NS = 320;

   // ==========================================================
   // test access port states
   typedef enum logic [15:0] {
      TAP_RESET      = 16'b0000_0000_0000_0001,
      TAP_IDLE       = 16'b0000_0000_0000_0010,
      TAP_SEL_DR     = 16'b0000_0000_0000_0100,
      TAP_CAPTURE_DR = 16'b0000_0000_0000_1000,
      TAP_SHIFT_DR   = 16'b0000_0000_0001_0000,
      TAP_EXIT1_DR   = 16'b0000_0000_0010_0000,
      TAP_PAUSE_DR   = 16'b0000_0000_0100_0000,
      TAP_EXIT2_DR   = 16'b0000_0000_1000_0000,
      TAP_UPDATE_DR  = 16'b0000_0001_0000_0000,
      TAP_SEL_IR     = 16'b0000_0010_0000_0000,
      TAP_CAPTURE_IR = 16'b0000_0100_0000_0000,
      TAP_SHIFT_IR   = 16'b0000_1000_0000_0000,
      TAP_EXIT1_IR   = 16'b0001_0000_0000_0000,
      TAP_PAUSE_IR   = 16'b0010_0000_0000_0000,
      TAP_EXIT2_IR   = 16'b0100_0000_0000_0000,
      TAP_UPDATE_IR  = 16'b1000_0000_0000_0000
   } bsc_tap_t;

endpackage : bsc_pkg

// ### src/bsc_sync.sv
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps

module bsc_sync
   import bsc_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // asynchronous input and synchronised output
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } bsc_sync_state_t;

   bsc_sync_state_t s_q;
   bsc_sync_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.meta = d;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stable;

endmodule : bsc_sync

// ### testbench/bsc_chain_chk.sv
// assertions on the chain's pins
`timescale 1ns/100ps
module bsc_chain_chk
   import bsc_pkg::*;
#(parameter int N_IN = 4, parameter int N_OUT = 6, parameter int N_BIDI = 80) (
   // clock, reset, link
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic tck,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic test_mode,
   // pads and core
   input wire logic [N_IN-1:0] in_pad_i,
   input wire logic [N_IN-1:0] core_in,
   input wire logic [N_OUT-1:0] core_out_d,
   input wire logic [N_OUT-1:0] core_out_en,
   input wire logic [N_OUT-1:0] out_pad_o,
   input wire logic [N_OUT-1:0] out_pad_oe,
   input wire logic [N_BIDI-1:0] bidi_pad_i,
   input wire logic [N_BIDI-1:0] core_bidi_in,
   input wire logic [N_BIDI-1:0] core_bidi_d,
   input wire logic [N_BIDI-1:0] core_bidi_en,
   input wire logic [N_BIDI-1:0] bidi_pad_o,
   input wire logic [N_BIDI-1:0] bidi_pad_oe
);
   // ==========================================================
   // properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_func;
      !test_mode && !$past(test_mode) && $past(nrst);
   endsequence
   sequence s_hold;
      test_mode && $past(test_mode);
   endsequence
   property p_in_obs;
      $past(nrst, 2) |-> core_in == $past(in_pad_i, 2);
   endproperty
   property p_bidi_obs;
      $past(nrst, 2) |-> core_bidi_in == $past(bidi_pad_i, 2);
   endproperty
   property p_out_func;
      s_func |-> out_pad_o == $past(core_out_d) && out_pad_oe == $past(core_out_en);
   endproperty
   property p_bidi_func;
      s_func |-> bidi_pad_o == $past(core_bidi_d) && bidi_pad_oe == $past(core_bidi_en);
   endproperty
   property p_tdo_fall;
      $changed(tdo) |-> !$past(tck, 3);
   endproperty
   property p_reset;
      disable iff (1'b0) !nrst |=> !tdo && !tdo_oe && out_pad_oe == '0 && bidi_pad_oe == '0;
   endproperty
   property p_out_hold;
      s_hold ##0 $changed({out_pad_o, out_pad_oe}) |-> !$past(tck, 4);
   endproperty
   property p_bidi_hold;
      s_hold ##0 $changed({bidi_pad_o, bidi_pad_oe}) |-> !$past(tck, 4);
   endproperty
   a_in_obs: assert property (p_in_obs) else $error("input cell path wrong");
   a_bidi_obs: assert property (p_bidi_obs) else $error("bidi observe path wrong");
   a_out_func: assert property (p_out_func) else $error("out pads ignore core");
   a_bidi_func: assert property (p_bidi_func) else $error("bidi pads ignore core");
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off tck fall");
   a_reset: assert property (p_reset) else $error("reset values wrong");
   a_out_hold: assert property (p_out_hold) else $error("out cells moved early");
   a_bidi_hold: assert property (p_bidi_hold) else $error("bidi cells moved early");
endmodule : bsc_chain_chk
bind bsc_chain bsc_chain_chk #(.N_IN(N_IN), .N_OUT(N_OUT), .N_BIDI(N_BIDI)) u_chk (
   .ref_clk(ref_clk), .nrst(nrst), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
   .test_mode(test_mode), .in_pad_i(in_pad_i), .core_in(core_in),
   .core_out_d(core_out_d), .core_out_en(core_out_en), .out_pad_o(out_pad_o),
   .out_pad_oe(out_pad_oe), .bidi_pad_i(bidi_pad_i), .core_bidi_in(core_bidi_in),
   .core_bidi_d(core_bidi_d), .core_bidi_en(core_bidi_en), .bidi_pad_o(bidi_pad_o),
   .bidi_pad_oe(bidi_pad_oe)
);

// ### testbench/bsc_tester.sv
// jtag tester model on the far side of the chain
`timescale 1ns/100ps
module bsc_tester (
   // clock and link
   input wire logic ref_clk,
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   // ==========================================================
   // tck rests low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one 320 ns tck period, tdo taken before the rise
   task automatic bit_io(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      repeat (4) @(negedge ref_clk);
      o = tdo;
      tck = 1'b1;
      repeat (4) @(negedge ref_clk);
      tck = 1'b0;
   endtask : bit_io
   task automatic tap_reset();
      logic o;
      repeat (5) bit_io(1'b1, 1'b0, o);
      bit_io(1'b0, 1'b0, o);
   endtask : tap_reset
   // idle to idle; bit i goes in and comes out i-th
   task automatic scan(input logic ir, input int n, input logic [511:0] din,
                       output logic [511:0] dout);
      logic o;
      dout = '0;
      bit_io(1'b1, 1'b0, o);
      if (ir) bit_io(1'b1, 1'b0, o);
      bit_io(1'b0, 1'b0, o);
      bit_io(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) bit_io(i == n - 1, din[i], dout[i]);
      bit_io(1'b1, 1'b0, o);
      bit_io(1'b0, 1'b0, o);
   endtask : scan
endmodule : bsc_tester

// ### testbench/tb_boundary_scan_cell_chain.sv
// self-checking bench of the boundary-scan chain
`timescale 1ns/100ps
module tb_boundary_scan_cell_chain;
   import bsc_pkg::*;
   // ==========================================================
   // wiring
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe, tdo_w, test_mode;
   logic [3:0] in_pad_i = 4'h5;
   logic [3:0] core_in;
   logic [5:0] core_out_d = 6'h2d;
   logic [5:0] core_out_en = 6'h1b;
   logic [5:0] out_pad_o, out_pad_oe;
   logic [79:0] core_bidi_d = 80'ha5c3_0f96_1234_5678_9abc;
   logic [79:0] core_bidi_en = 80'hf0f0_3c3c_aaaa_5555_00ff;
   logic [79:0] ext_bidi = 80'h1357_9bdf_2468_ace0_7777;
   logic [79:0] bidi_pad_i, bidi_pad_o, bidi_pad_oe, core_bidi_in;
   logic [511:0] dout;
   int failures = 0;
   int num_checks = 0;
   always #20 ref_clk = ~ref_clk;
   assign tdo_w = tdo_oe ? tdo : ~tdo;
   assign bidi_pad_i = (bidi_pad_oe & bidi_pad_o) | (~bidi_pad_oe & ext_bidi);
   bsc_chain uut (.ref_clk(ref_clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .in_pad_i(in_pad_i), .core_in(core_in),
      .core_out_d(core_out_d), .core_out_en(core_out_en), .out_pad_o(out_pad_o),
      .out_pad_oe(out_pad_oe), .bidi_pad_i(bidi_pad_i), .bidi_pad_o(bidi_pad_o),
      .bidi_pad_oe(bidi_pad_oe), .core_bidi_d(core_bidi_d), .core_bidi_en(core_bidi_en),
      .core_bidi_in(core_bidi_in), .test_mode(test_mode));
   bsc_tester tst (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));
   // ==========================================================
   // helpers and scenarios
   task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic logic [255:0] exp_cap(input logic [79:0] obs);
      logic [255:0] e;
      e = '0;
      for (int i = 0; i < 4; i++) e[255-i] = in_pad_i[i];
      for (int j = 0; j < 6; j++) e[251-2*j-:2] = {core_out_d[j], core_out_en[j]};
      for (int k = 0; k < 80; k++) e[239-3*k-:3] = {core_bidi_d[k], obs[k], core_bidi_en[k]};
      return e;
   endfunction : exp_cap
   task automatic t_bypass();
      chk("tdo_oe", 1'b0, tdo_oe);
      tst.scan(1'b1, 4, 512'hf, dout);
      chk("ir capture", 4'h1, dout[3:0]);
      tst.scan(1'b0, 4, 512'h6, dout);
      chk("bypass", 4'hc, dout[3:0]);
   endtask : t_bypass
   task automatic t_sample();
      logic [79:0] obs;
      obs = (core_bidi_en & core_bidi_d) | (~core_bidi_en & ext_bidi);
      tst.scan(1'b1, 4, 512'h1, dout);
      tst.scan(1'b0, 264, 512'h96, dout);
      chk("sample", exp_cap(obs), dout[255:0]);
      chk("length", 8'h96, dout[263:256]);
      chk("test_mode", 1'b0, test_mode);
      chk("out_pad_o", core_out_d, out_pad_o);
   endtask : t_sample
   task automatic t_extest();
      logic [255:0] c, prev;
      logic [5:0] eo, ee;
      logic [79:0] bo, be, obs;
      tst.scan(1'b1, 4, 512'h0, dout);
      chk("test_mode", 1'b1, test_mode);
      for (int it = 0; it < 2; it++) begin
         prev = c;
         c = it ? ~{32{8'h6c}} : {32{8'h6c}};
         tst.scan(1'b0, 256, {256'h0, c}, dout);
         for (int j = 0; j < 6; j++) {eo[j], ee[j]} = c[251-2*j-:2];
         for (int k = 0; k < 80; k++) begin
            {bo[k], be[k]} = {c[239-3*k], c[237-3*k]};
            obs[k] = prev[237-3*k] ? prev[239-3*k] : ext_bidi[k];
         end
         chk("out_pad_o", eo, out_pad_o);
         chk("out_pad_oe", ee, out_pad_oe);
         chk("bidi_pad_o", bo, bidi_pad_o);
         chk("bidi_pad_oe", be, bidi_pad_oe);
         if (it == 1) chk("extest capture", exp_cap(obs), dout[255:0]);
      end
      tst.tap_reset();
      chk("test_mode", 1'b0, test_mode);
      chk("out_pad_oe", core_out_en, out_pad_oe);
   endtask : t_extest
   task automatic final_report();
      if (failures == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   initial begin
      repeat (20) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (3) @(negedge ref_clk);
      tst.tap_reset();
      t_bypass();
      t_sample();
      t_extest();
      final_report();
   end
endmodule : tb_boundary_scan_cell_chain
